// File: testbench/sgps_gear_model.sv
// switchgear model: auxiliary contacts that follow the drive outputs
`timescale 1ns/100ps
module sgps_gear_model #(
	parameter int DELAY = 5
) (
	input  wire logic  pclk,
	input  wire logic  close_drive,
	input  wire logic  open_drive,
	input  wire logic  stuck,
	output logic       fb_closed_in,
	output logic       fb_open_in
);
	int cnt_ff;
	initial begin
		fb_closed_in = 1'b0;
		fb_open_in = 1'b1;
		cnt_ff = 0;
	end
	// both contacts wired, both leave their end position on travel
	always @(posedge pclk) begin
		if (close_drive || open_drive) begin
			cnt_ff <= cnt_ff + 1;
			if (cnt_ff == 0) begin
				fb_closed_in <= 1'b0;
				fb_open_in <= 1'b0;
			end else if (cnt_ff == DELAY && !stuck) begin
				fb_closed_in <= close_drive;
				fb_open_in <= open_drive;
			end
		end else
			cnt_ff <= 0;
	end
endmodule // sgps_gear_model

// File: testbench/sgps_tb_top.sv
// self-checking bench of the switchgear position supervisor
`timescale 1ns/100ps
`include "sgps_map.svh"
module sgps_tb_top;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        fb_closed_in;
	logic        fb_open_in;
	logic        prot_close_in;
	logic        prot_open_in;
	logic        close_drive;
	logic        open_drive;
	logic        pos_closed;
	logic        pos_open;
	logic        pos_indeterm;
	logic        pos_disturbed;
	logic [1:0]  pos_code;
	logic        single_feedback_flag;
	logic        command_success_flag;
	logic        stuck;
	logic        ok;
	logic        ind;
	int          len;
	int          n_errors;
	int          num_checks;

	sgps_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.fb_closed_in, .fb_open_in, .prot_close_in, .prot_open_in, .close_drive, .open_drive, .pos_closed,
		.pos_open, .pos_indeterm, .pos_disturbed, .pos_code, .single_feedback_flag, .command_success_flag);
	sgps_gear_model model (.pclk, .close_drive, .open_drive, .stuck, .fb_closed_in, .fb_open_in);

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// ==========
	// tasks
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic fail(input string m);
		n_errors++;
		$display("wrong value at %0t: %s", $time, m);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
			fail($sformatf("got %0h expected %0h", got, exp));
	endtask
	task automatic chk_pos(input logic [1:0] c, input logic s);
		repeat (2) @(negedge pclk);
		num_checks++;
		if ({pos_code, pos_closed, pos_open, pos_indeterm, pos_disturbed, single_feedback_flag} !==
				{c, c == 2'h2, c == 2'h1, c == 2'h0, c == 2'h3, s})
			fail($sformatf("position code %0d expected %0d", pos_code, c));
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
			output logic e);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		// answer taken at the rising edge that ends the access
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (pready !== 1'b1) begin
			fail("no pready");
			test_done;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, x);
		chk(32'(e), 32'(xe));
	endtask
	task automatic move(input logic [1:0] c, input logic pr);
		int k;
		if (pr) begin
			@(posedge pclk);
			prot_close_in <= c[0];
			prot_open_in <= c[1];
		end else
			wr(`SGPS_OFF_CMD, {30'h0, c});
		len = 0;
		ok = 1'b0;
		ind = 1'b0;
		for (k = 0; k < 400; k++) begin
			@(negedge pclk);
			ok |= (command_success_flag === 1'b1);
			if (close_drive === 1'b1 || open_drive === 1'b1) begin
				len++;
				ind |= (pos_code === `SGPS_CODE_INDETERM);
			end else if (len > 0 || k > 9)
				break;
		end
		@(posedge pclk);
		prot_close_in <= 1'b0;
		prot_open_in <= 1'b0;
		if (k == 400) begin
			fail("drive never released");
			test_done;
		end
	endtask

	// ==========
	// sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		prot_close_in = 1'b0;
		prot_open_in = 1'b0;
		stuck = 1'b0;
		n_errors = 0;
		num_checks = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		rdc(`SGPS_OFF_CTRL, 32'h3, 1'b0);
		rdc(`SGPS_OFF_TCLOSE, 32'h0F4240, 1'b0);
		rdc(`SGPS_OFF_TSETTLE, 32'h0186A0, 1'b0);
		rdc(`SGPS_OFF_STATUS, 32'h1012, 1'b0);
		rdc(8'h18, 32'h0, 1'b1);
		wr(`SGPS_OFF_TCLOSE, 32'hFF000014);
		wr(`SGPS_OFF_TOPEN, 32'hC);
		wr(`SGPS_OFF_TSETTLE, 32'h6);
		rdc(`SGPS_OFF_TCLOSE, 32'h14, 1'b0);
		rdc(`SGPS_OFF_TOPEN, 32'hC, 1'b0);
		move(2'h1, 1'b0);
		chk(32'(ok), 32'h1);
		chk(32'(ind), 32'h1);
		chk(32'(len > 5 && len < 20), 32'h1);
		chk_pos(2'h2, 1'b0);
		stuck = 1'b1;
		move(2'h2, 1'b0);
		chk(32'(len), 32'd12);
		chk(32'(ok), 32'h0);
		chk_pos(2'h3, 1'b0);
		stuck = 1'b0;
		move(2'h2, 1'b0);
		chk(32'(ok), 32'h1);
		chk_pos(2'h1, 1'b0);
		wr(`SGPS_OFF_CTRL, 32'h1);
		chk_pos(2'h1, 1'b1);
		move(2'h1, 1'b0);
		chk(32'(ok), 32'h1);
		chk_pos(2'h2, 1'b1);
		move(2'h2, 1'b0);
		chk(32'(len), 32'd12);
		chk(32'(ok), 32'h0);
		chk_pos(2'h1, 1'b1);
		stuck = 1'b1;
		move(2'h1, 1'b0);
		chk(32'(len), 32'd20);
		chk_pos(2'h3, 1'b1);
		wr(`SGPS_OFF_CTRL, 32'h5);
		move(2'h1, 1'b0);
		chk_pos(2'h0, 1'b1);
		repeat (10) @(posedge pclk);
		chk_pos(2'h2, 1'b1);
		wr(`SGPS_OFF_CTRL, 32'h0);
		chk_pos(2'h3, 1'b0);
		stuck = 1'b0;
		wr(`SGPS_OFF_CTRL, 32'h3);
		move(2'h1, 1'b1);
		chk(32'(len), 32'd0);
		wr(`SGPS_OFF_CTRL, 32'hB);
		move(2'h1, 1'b1);
		chk(32'(ok), 32'h1);
		chk_pos(2'h2, 1'b0);
		move(2'h2, 1'b1);
		chk_pos(2'h1, 1'b0);
		rdc(`SGPS_OFF_STATUS, 32'h1212, 1'b0);
		wr(`SGPS_OFF_STATUS, 32'h200);
		rdc(`SGPS_OFF_STATUS, 32'h1012, 1'b0);
		wr(`SGPS_OFF_CTRL, 32'h2);
		chk_pos(2'h1, 1'b1);
		move(2'h3, 1'b0);
		chk(32'(ok), 32'h1);
		chk_pos(2'h1, 1'b1);
		move(2'h1, 1'b0);
		chk(32'(len), 32'd20);
		chk(32'(ok), 32'h0);
		chk_pos(2'h2, 1'b1);
		test_done;
	end
endmodule // sgps_tb_top

// File: testbench/sgps_top_asserts.sv
// port assertions of the switchgear position supervisor
`timescale 1ns/100ps
module sgps_top_asserts (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic        close_drive,
	input  wire logic        open_drive,
	input  wire logic        pos_closed,
	input  wire logic        pos_open,
	input  wire logic        pos_indeterm,
	input  wire logic        pos_disturbed,
	input  wire logic [1:0]  pos_code,
	input  wire logic        command_success_flag
);
	// ==========
	// properties
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	code_flags_a: assert property (pos_code == {pos_closed | pos_disturbed, pos_open | pos_disturbed})
		else $error("code and flags disagree");
	one_flag_a: assert property ($onehot({pos_closed, pos_open, pos_indeterm, pos_disturbed}))
		else $error("not exactly one position flag");
	drive_excl_a: assert property (!(close_drive && open_drive))
		else $error("both drives high");
	travel_ok_a: assert property ((close_drive || open_drive) [*3] |-> !pos_disturbed)
		else $error("disturbed while travelling");
	succ_pulse_a: assert property (command_success_flag |=> !command_success_flag)
		else $error("success longer than one cycle");
	succ_end_a: assert property (command_success_flag |->
		($fell(close_drive) && pos_closed) || ($fell(open_drive) && pos_open))
		else $error("success without drive release");
	close_end_a: assert property ($fell(close_drive) |-> !pos_open)
		else $error("close ended in open");
	open_end_a: assert property ($fell(open_drive) |-> !pos_closed)
		else $error("open ended in closed");
	apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not a one cycle answer");
	apb_err_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
endmodule // sgps_top_asserts

bind sgps_top sgps_top_asserts u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .close_drive,
	.open_drive, .pos_closed, .pos_open, .pos_indeterm, .pos_disturbed, .pos_code, .command_success_flag);

// File: verilog/sgps_map.svh
// register map, field positions, reset values and codes of the switchgear position supervisor
`ifndef SGPS_MAP_SVH
`define SGPS_MAP_SVH

`define SGPS_ADDR_W          8
`define SGPS_TIME_W          24

`define SGPS_OFF_CTRL        8'h00
`define SGPS_OFF_CMD         8'h04
`define SGPS_OFF_TCLOSE      8'h08
`define SGPS_OFF_TOPEN       8'h0C
`define SGPS_OFF_TSETTLE     8'h10
`define SGPS_OFF_STATUS      8'h14

`define SGPS_CTRL_CLOSE_WIRED 0
`define SGPS_CTRL_OPEN_WIRED  1
`define SGPS_CTRL_SETTLE_EN   2
`define SGPS_CTRL_PROT_ROUTE  3
`define SGPS_CTRL_W           4
`define SGPS_CTRL_RESET       4'h3

`define SGPS_CMD_CLOSE       0
`define SGPS_CMD_OPEN        1

`define SGPS_ST_CLOSED       0
`define SGPS_ST_OPEN         1
`define SGPS_ST_INDETERM     2
`define SGPS_ST_DISTURBED    3
`define SGPS_ST_CODE_LO      4
`define SGPS_ST_CODE_HI      5
`define SGPS_ST_SINGLE       6
`define SGPS_ST_CLOSE_DRV    7
`define SGPS_ST_OPEN_DRV     8
`define SGPS_ST_SUCCESS_SEEN 9
`define SGPS_ST_STATE_LO     12
`define SGPS_ST_STATE_HI     15

`define SGPS_TCLOSE_RESET    24'h0F4240
`define SGPS_TOPEN_RESET     24'h0F4240
`define SGPS_TSETTLE_RESET   24'h0186A0

`define SGPS_CODE_INDETERM   2'h0
`define SGPS_CODE_OPEN       2'h1
`define SGPS_CODE_CLOSED     2'h2
`define SGPS_CODE_DISTURBED  2'h3

`endif

// File: verilog/sgps_pkg.sv
// types of the switchgear position supervisor
package sgps_pkg;

	typedef enum logic [3:0] {
		SGPS_IDLE    = 4'h1,
		SGPS_CLOSING = 4'h2,
		SGPS_OPENING = 4'h4,
		SGPS_SETTLE  = 4'h8
	} sgps_state_type;

	typedef logic [1:0] sgps_code_type;

endpackage

// File: verilog/sgps_timer.sv
// travel and settle timer: counts clock cycles against a terminal value
`timescale 1ns/100ps
`include "sgps_map.svh"
module sgps_timer (
	input  wire logic  pclk,
	input  wire logic  presetn,
	sgps_tmr_if.timer  tmr
);
	logic [`SGPS_TIME_W-1:0] cnt_ff;
	logic [`SGPS_TIME_W-1:0] term_ff;
	logic                    run_ff;
	logic [`SGPS_TIME_W-1:0] cnt_inc;

	assign cnt_inc     = cnt_ff + `SGPS_TIME_W'(1);
	// expire is high in the last counted cycle, so a run lasts exactly term cycles
	assign tmr.expire  = run_ff & (cnt_inc == term_ff); // [R19]
	assign tmr.running = run_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff  <= '0;
			term_ff <= `SGPS_TIME_W'(1);
			run_ff  <= 1'b0; // [R20]
		end else if (tmr.start) begin
			cnt_ff  <= '0;
			// zero is taken as one cycle
			term_ff <= (tmr.terminal == '0) ? `SGPS_TIME_W'(1) : tmr.terminal;
			run_ff  <= 1'b1;
		end else if (tmr.expire) begin
			run_ff  <= 1'b0;
		end else if (run_ff) begin
			cnt_ff  <= cnt_inc; // [R19]
		end
	end
endmodule // sgps_timer

// File: verilog/sgps_tmr_if.sv
// timer carrier between the supervisor and its travel / settle timer
`timescale 1ns/100ps
`include "sgps_map.svh"
interface sgps_tmr_if;
	logic                     start;
	logic [`SGPS_TIME_W-1:0]  terminal;
	logic                     running;
	logic                     expire;

	modport timer (input start, input terminal, output running, output expire);
	modport user  (output start, output terminal, input running, input expire);
endinterface

// File: verilog/sgps_top.sv
// switchgear position supervisor: feedback validation, travel supervision, apb registers
// Contract
// (R1) installer wires at least one feedback contact, preferably both
// (R2) each drive lasts at most its travel time, released early on new position
// (R3) close command starts close timer; indeterminate while it runs
// (R4) closed feedback before expiry gives closed, expiry gives disturbed
// (R5) open command likewise with open timer, open flag or disturbed
// (R6) position code 0 indeterm, 1 open, 2 closed, 3 disturbed, matching flags
// (R7) two contacts: low/high gives open code 1, high/low gives closed code 2
// (R8) two contacts equal: indeterminate while timer runs, otherwise disturbed
// (R9) feedback sampled every cycle, position re-evaluated on every change
// (R10) single feedback contact raises the single feedback flag
// (R11) single contact supervises only the direction of its own contact
// (R12) closed-only: close starts timer, indeterminate, closed and success before expiry
// (R13) closed-only: expiry before end position clears indeterminate, reports disturbed
// (R14) after travel expiry optional settle timer keeps indeterminate, then end position
// (R15) closed-only: high closed, low indeterminate during close timer else open
// (R16) no feedback input assigned gives code 3 disturbed
// (R17) close, open and settle times are set separately per unit
// (R18) protection commands may be routed onto the control drive outputs
// (R19) timers count clock cycles and expire when the count hits the setting
// (R20) success pulses one cycle on timely end position; reset idles timers, drives
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "sgps_map.svh"
module sgps_top (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [`SGPS_ADDR_W-1:0]  paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic                     fb_closed_in,
	input  wire logic                     fb_open_in,
	input  wire logic                     prot_close_in,
	input  wire logic                     prot_open_in,
	output logic                          close_drive,
	output logic                          open_drive,
	output logic                          pos_closed,
	output logic                          pos_open,
	output logic                          pos_indeterm,
	output logic                          pos_disturbed,
	output logic      [1:0]               pos_code,
	output logic                          single_feedback_flag,
	output logic                          command_success_flag
);
	// ==========================================================
	// declarations
	sgps_tmr_if                tmr ();
	sgps_pkg::sgps_state_type  state_ff;
	sgps_pkg::sgps_state_type  nxt_state;
	logic [3:0]                s1_ff;
	logic [3:0]                s2_ff;
	logic [3:0]                s3_ff;
	logic [3:0]                in_ff;
	logic [3:0]                in_prev_ff;
	logic [`SGPS_CTRL_W-1:0]   ctrl_ff;
	logic [`SGPS_TIME_W-1:0]   tclose_ff;
	logic [`SGPS_TIME_W-1:0]   topen_ff;
	logic [`SGPS_TIME_W-1:0]   tsettle_ff;
	logic                      hold_dist_ff;
	logic                      force_end_ff;
	logic                      success_seen_ff;
	logic [31:0]               prdata_ff;
	logic                      pready_ff;
	logic                      pslverr_ff;
	logic                      close_drive_ff;
	logic                      open_drive_ff;
	logic                      pos_closed_ff;
	logic                      pos_open_ff;
	logic                      pos_indeterm_ff;
	logic                      pos_disturbed_ff;
	sgps_pkg::sgps_code_type   pos_code_ff;
	logic                      single_ff;
	logic                      success_ff;
	sgps_pkg::sgps_code_type   nxt_code;
	logic                      nxt_success;
	logic                      nxt_hold_set;
	logic                      nxt_force_set;
	logic                      fb_c;
	logic                      fb_o;
	logic                      cw;
	logic                      ow;
	logic                      setup;
	logic                      wr_access;
	logic                      mapped;
	logic                      cmd_wr;
	logic                      req_close;
	logic                      req_open;
	logic                      fb_changed;
	logic                      accept;

	sgps_timer u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.tmr     (tmr)
	);

	// ==========================================================
	// input synchronisers: closed, open, prot close, prot open
	logic [3:0] pins;
	assign pins = {prot_open_in, prot_close_in, fb_open_in, fb_closed_in};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else begin
			s1_ff <= pins;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// change taken once stage two and three agree, checked every cycle
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_filt
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					in_ff[gi]      <= 1'b0;
					in_prev_ff[gi] <= 1'b0;
				end else begin
					if (s2_ff[gi] == s3_ff[gi]) begin
						in_ff[gi] <= s3_ff[gi]; // [R9]
					end
					in_prev_ff[gi] <= in_ff[gi];
				end
			end
		end
	endgenerate

	assign fb_c       = in_ff[0];
	assign fb_o       = in_ff[1];
	assign fb_changed = (in_ff[1:0] != in_prev_ff[1:0]); // [R9]
	assign cw         = ctrl_ff[`SGPS_CTRL_CLOSE_WIRED];
	assign ow         = ctrl_ff[`SGPS_CTRL_OPEN_WIRED];

	// ==========================================================
	// apb slave
	assign setup     = psel & ~penable;
	assign wr_access = psel & penable & pwrite;
	assign mapped    = (paddr == `SGPS_OFF_CTRL) | (paddr == `SGPS_OFF_CMD) | (paddr == `SGPS_OFF_TCLOSE) |
	                   (paddr == `SGPS_OFF_TOPEN) | (paddr == `SGPS_OFF_TSETTLE) | (paddr == `SGPS_OFF_STATUS);
	assign cmd_wr    = wr_access & (paddr == `SGPS_OFF_CMD);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= '0;
		end else begin
			pready_ff  <= setup;
			pslverr_ff <= setup & ~mapped;
			prdata_ff  <= '0;
			if (setup & ~pwrite) begin
				unique case (paddr)
					`SGPS_OFF_CTRL:    prdata_ff <= 32'(ctrl_ff);
					`SGPS_OFF_TCLOSE:  prdata_ff <= 32'(tclose_ff);
					`SGPS_OFF_TOPEN:   prdata_ff <= 32'(topen_ff);
					`SGPS_OFF_TSETTLE: prdata_ff <= 32'(tsettle_ff);
					`SGPS_OFF_STATUS: begin
						prdata_ff[`SGPS_ST_CLOSED]       <= pos_closed_ff;
						prdata_ff[`SGPS_ST_OPEN]         <= pos_open_ff;
						prdata_ff[`SGPS_ST_INDETERM]     <= pos_indeterm_ff;
						prdata_ff[`SGPS_ST_DISTURBED]    <= pos_disturbed_ff;
						prdata_ff[`SGPS_ST_CODE_HI:`SGPS_ST_CODE_LO]   <= pos_code_ff;
						prdata_ff[`SGPS_ST_SINGLE]       <= single_ff;
						prdata_ff[`SGPS_ST_CLOSE_DRV]    <= close_drive_ff;
						prdata_ff[`SGPS_ST_OPEN_DRV]     <= open_drive_ff;
						prdata_ff[`SGPS_ST_SUCCESS_SEEN] <= success_seen_ff;
						prdata_ff[`SGPS_ST_STATE_HI:`SGPS_ST_STATE_LO] <= state_ff;
					end
					default:           prdata_ff <= '0;
				endcase
			end
		end
	end

	// configuration per unit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff    <= `SGPS_CTRL_RESET;
			tclose_ff  <= `SGPS_TCLOSE_RESET;
			tsettle_ff <= `SGPS_TSETTLE_RESET;
			topen_ff   <= `SGPS_TOPEN_RESET;
		end else if (wr_access) begin
			if (paddr == `SGPS_OFF_CTRL) begin
				ctrl_ff <= pwdata[`SGPS_CTRL_W-1:0];
			end
			if (paddr == `SGPS_OFF_TCLOSE) begin
				tclose_ff <= pwdata[`SGPS_TIME_W-1:0]; // [R17]
			end
			if (paddr == `SGPS_OFF_TOPEN) begin
				topen_ff <= pwdata[`SGPS_TIME_W-1:0]; // [R17]
			end
			if (paddr == `SGPS_OFF_TSETTLE) begin
				tsettle_ff <= pwdata[`SGPS_TIME_W-1:0]; // [R17]
			end
		end
	end

	// sticky success, set wins over write-one-to-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			success_seen_ff <= 1'b0;
		end else if (nxt_success) begin
			success_seen_ff <= 1'b1;
		end else if (wr_access & (paddr == `SGPS_OFF_STATUS) & pwdata[`SGPS_ST_SUCCESS_SEEN]) begin
			success_seen_ff <= 1'b0;
		end
	end

	// ==========================================================
	// command intake: open wins, only one movement at a time
	assign req_open  = (cmd_wr & pwdata[`SGPS_CMD_OPEN]) |
	                   (ctrl_ff[`SGPS_CTRL_PROT_ROUTE] & in_ff[3] & ~in_prev_ff[3]); // [R18]
	assign req_close = (cmd_wr & pwdata[`SGPS_CMD_CLOSE]) |
	                   (ctrl_ff[`SGPS_CTRL_PROT_ROUTE] & in_ff[2] & ~in_prev_ff[2]); // [R18]
	assign accept    = (state_ff == sgps_pkg::SGPS_IDLE) & (req_open | req_close);

	// ==========================================================
	// position evaluation from feedback, state and end-of-move flags
	always_comb begin
		nxt_code = `SGPS_CODE_DISTURBED;
		if (cw & ow) begin
			if (fb_c & ~fb_o) begin
				nxt_code = `SGPS_CODE_CLOSED; // [R7]
			end else if (~fb_c & fb_o) begin
				nxt_code = `SGPS_CODE_OPEN; // [R7]
			end else if (state_ff != sgps_pkg::SGPS_IDLE) begin
				nxt_code = `SGPS_CODE_INDETERM; // [R8] [R3] [R5]
			end else begin
				nxt_code = `SGPS_CODE_DISTURBED; // [R8] [R4]
			end
		end else if (cw) begin
			if (hold_dist_ff) begin
				nxt_code = `SGPS_CODE_DISTURBED; // [R13]
			end else if (state_ff == sgps_pkg::SGPS_SETTLE) begin
				nxt_code = `SGPS_CODE_INDETERM; // [R14]
			end else if (fb_c | force_end_ff) begin
				nxt_code = `SGPS_CODE_CLOSED; // [R15] [R14]
			end else if (state_ff == sgps_pkg::SGPS_CLOSING) begin
				nxt_code = `SGPS_CODE_INDETERM; // [R12] [R15]
			end else begin
				nxt_code = `SGPS_CODE_OPEN; // [R15]
			end
		end else if (ow) begin
			if (hold_dist_ff) begin
				nxt_code = `SGPS_CODE_DISTURBED;
			end else if (state_ff == sgps_pkg::SGPS_SETTLE) begin
				nxt_code = `SGPS_CODE_INDETERM; // [R14]
			end else if (fb_o | force_end_ff) begin
				nxt_code = `SGPS_CODE_OPEN;
			end else if (state_ff == sgps_pkg::SGPS_OPENING) begin
				nxt_code = `SGPS_CODE_INDETERM;
			end else begin
				nxt_code = `SGPS_CODE_CLOSED;
			end
		end else begin
			nxt_code = `SGPS_CODE_DISTURBED; // [R16]
		end
	end

	// ==========================================================
	// movement supervision
	always_comb begin
		nxt_state     = state_ff;
		nxt_success   = 1'b0;
		nxt_hold_set  = 1'b0;
		nxt_force_set = 1'b0;
		tmr.start     = 1'b0;
		tmr.terminal  = tclose_ff;
		unique case (state_ff)
			sgps_pkg::SGPS_IDLE: begin
				if (accept & req_open) begin
					nxt_state    = sgps_pkg::SGPS_OPENING;
					tmr.start    = 1'b1; // [R5]
					tmr.terminal = topen_ff;
				end else if (accept) begin
					nxt_state    = sgps_pkg::SGPS_CLOSING;
					tmr.start    = 1'b1; // [R3]
				end
			end
			sgps_pkg::SGPS_CLOSING: begin
				if (cw & (nxt_code == `SGPS_CODE_CLOSED)) begin
					nxt_state   = sgps_pkg::SGPS_IDLE; // [R2] [R4]
					nxt_success = 1'b1; // [R12] [R20]
				end else if (tmr.expire) begin
					if (cw & ~ow & ctrl_ff[`SGPS_CTRL_SETTLE_EN]) begin
						nxt_state    = sgps_pkg::SGPS_SETTLE; // [R14]
						tmr.start    = 1'b1;
						tmr.terminal = tsettle_ff;
					end else begin
						nxt_state    = sgps_pkg::SGPS_IDLE; // [R2]
						nxt_hold_set = cw & ~ow; // [R13] [R11]
					end
				end
			end
			sgps_pkg::SGPS_OPENING: begin
				if (ow & (nxt_code == `SGPS_CODE_OPEN)) begin
					nxt_state   = sgps_pkg::SGPS_IDLE; // [R2] [R5]
					nxt_success = 1'b1; // [R20]
				end else if (tmr.expire) begin
					if (ow & ~cw & ctrl_ff[`SGPS_CTRL_SETTLE_EN]) begin
						nxt_state    = sgps_pkg::SGPS_SETTLE; // [R14]
						tmr.start    = 1'b1;
						tmr.terminal = tsettle_ff;
					end else begin
						nxt_state    = sgps_pkg::SGPS_IDLE; // [R2]
						nxt_hold_set = ow & ~cw; // [R11]
					end
				end
			end
			sgps_pkg::SGPS_SETTLE: begin
				if (tmr.expire) begin
					nxt_state     = sgps_pkg::SGPS_IDLE;
					nxt_force_set = 1'b1; // [R14]
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= sgps_pkg::SGPS_IDLE; // [R20]
		end else begin
			state_ff <= nxt_state;
		end
	end

	// end-of-move flags live until feedback changes or a new command; set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_dist_ff <= 1'b0;
			force_end_ff <= 1'b0;
		end else begin
			if (fb_changed | accept) begin
				hold_dist_ff <= 1'b0;
				force_end_ff <= 1'b0;
			end
			if (nxt_hold_set) begin
				hold_dist_ff <= 1'b1;
			end
			if (nxt_force_set) begin
				force_end_ff <= 1'b1;
			end
		end
	end

	// ==========================================================
	// registered outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			close_drive_ff   <= 1'b0; // [R20]
			open_drive_ff    <= 1'b0;
			pos_closed_ff    <= 1'b0;
			pos_open_ff      <= 1'b0;
			pos_indeterm_ff  <= 1'b0;
			pos_disturbed_ff <= 1'b1;
			pos_code_ff      <= `SGPS_CODE_DISTURBED;
			single_ff        <= 1'b0;
			success_ff       <= 1'b0;
		end else begin
			close_drive_ff   <= (nxt_state == sgps_pkg::SGPS_CLOSING); // [R2]
			open_drive_ff    <= (nxt_state == sgps_pkg::SGPS_OPENING); // [R2]
			pos_code_ff      <= nxt_code; // [R6]
			pos_closed_ff    <= (nxt_code == `SGPS_CODE_CLOSED); // [R6]
			pos_open_ff      <= (nxt_code == `SGPS_CODE_OPEN);
			pos_indeterm_ff  <= (nxt_code == `SGPS_CODE_INDETERM);
			pos_disturbed_ff <= (nxt_code == `SGPS_CODE_DISTURBED);
			single_ff        <= cw ^ ow; // [R10]
			success_ff       <= nxt_success; // [R20]
		end
	end

	assign prdata               = prdata_ff;
	assign pready               = pready_ff;
	assign pslverr              = pslverr_ff;
	assign close_drive          = close_drive_ff;
	assign open_drive           = open_drive_ff;
	assign pos_closed           = pos_closed_ff;
	assign pos_open             = pos_open_ff;
	assign pos_indeterm         = pos_indeterm_ff;
	assign pos_disturbed        = pos_disturbed_ff;
	assign pos_code             = pos_code_ff;
	assign single_feedback_flag = single_ff;
	assign command_success_flag = success_ff;
endmodule // sgps_top
